// ---- rtl/pcs_defs.vh ----
// Register map, field positions and reset values for the port and
// serial clock setup bank.
// Assumes inclusion by plain name from rtl/ files.
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH

`define PCS_ADDR_W        4
`define PCS_DATA_W        16
`define PCS_OFF_LATCH     4'h0
`define PCS_OFF_DIR       4'h1
`define PCS_OFF_IBUF      4'h2
`define PCS_OFF_CLKEN     4'h3
`define PCS_OFF_PRESC     4'h4
`define PCS_BIT_CS        4
`define PCS_BIT_IBUF      1
`define PCS_BIT_GATE      2
`define PCS_PRS_LO        0
`define PCS_PRS_HI        3
`define PCS_RST_LATCH     8'h00
`define PCS_RST_DIR       8'hFF
`define PCS_RST_IBUF      8'h00
`define PCS_RST_CLKEN     8'h00
`define PCS_RST_PRESC     16'h0000
`define PCS_PRESC_MASK    16'h00FF

`endif

// ---- rtl/pcs_prescaler.v ----
// Power-of-two prescaler giving a one-cycle enable pulse train.
// Assumes a free-running system clock and synchronous active-low reset.
`timescale 1ns/1ps
module pcs_prescaler #(
    parameter CNT_W = 15
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         resetn,
    // Control
    input  wire         run,
    input  wire [3:0]   sel,
    // Divided clock enable
    output reg          tick_r
);
    reg  [CNT_W-1:0] cnt_r;
    wire [CNT_W-1:0] mask;

    // Mask of low sel bits; tick when all of them are set
    assign mask = ~({CNT_W{1'b1}} << sel);

    always @(posedge sys_clk) begin
        if (!resetn) begin
            cnt_r  <= {CNT_W{1'b0}};
            tick_r <= 1'b0;
        end else if (!run) begin
            // Gate off: counter cleared so the divided clock stops
            cnt_r  <= {CNT_W{1'b0}};
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            tick_r <= ((cnt_r & mask) == mask);
        end
    end
endmodule

// ---- rtl/pcs_setup_bank.v ----
// Setup register bank: chip select pin, input buffer select, serial
// unit clock gate and first operation clock prescaler.
// Assumes a single-cycle register port master on sys_clk.
//
// Summary of operation
// - Output mode drives latch bit onto pin
// - Input mode reads pin level at bit
// - Direction 0 output buffer on, 1 off
// - Buffer select: 0 normal, 1 TTL
// - Clock gate 0 stops, 1 supplies clock
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pcs_defs.vh"
module pcs_setup_bank (
    // Clock and reset
    input  wire                    sys_clk,
    input  wire                    resetn,
    // Register port
    input  wire [`PCS_ADDR_W-1:0]  reg_addr,
    input  wire [`PCS_DATA_W-1:0]  reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [`PCS_DATA_W-1:0]  reg_rdata_r,
    // Chip select pin
    input  wire                    cs_pin_i,
    output reg                     cs_pin_o_r,
    output reg                     cs_pin_oe_r,
    // Serial data input buffer type
    output reg                     ttl_sel_r,
    // Serial array unit clocking
    output reg                     unit_clk_en_r,
    output reg                     op_clk_tick_r
);
    reg  [7:0]  latch_r;
    reg  [7:0]  dir_r;
    reg  [7:0]  ibuf_r;
    reg  [7:0]  clken_r;
    reg  [15:0] presc_r;
    reg  [2:0]  cs_sync_r;
    reg         cs_lvl_r;
    reg  [15:0] rd_nxt;
    reg  [7:0]  latch_view;
    wire        tick;

    // Pin sample: level changes once stages two and three agree
    always @(posedge sys_clk) begin
        if (!resetn) begin
            cs_sync_r <= 3'h0;
            cs_lvl_r  <= 1'b0;
        end else begin
            cs_sync_r <= {cs_sync_r[1:0], cs_pin_i};
            if (cs_sync_r[1] == cs_sync_r[2])
                cs_lvl_r <= cs_sync_r[2];
        end
    end

    // Each write lands only in the addressed register
    always @(posedge sys_clk) begin
        if (!resetn) begin
            latch_r <= `PCS_RST_LATCH;
            dir_r   <= `PCS_RST_DIR;
            ibuf_r  <= `PCS_RST_IBUF;
            clken_r <= `PCS_RST_CLKEN;
            presc_r <= `PCS_RST_PRESC;
        end else if (reg_wr) begin
            if (reg_addr == `PCS_OFF_LATCH)
                latch_r <= reg_wdata[7:0];
            else if (reg_addr == `PCS_OFF_DIR)
                dir_r <= reg_wdata[7:0];
            else if (reg_addr == `PCS_OFF_IBUF)
                ibuf_r <= reg_wdata[7:0];
            else if (reg_addr == `PCS_OFF_CLKEN)
                clken_r <= reg_wdata[7:0];
            else if (reg_addr == `PCS_OFF_PRESC)
                presc_r <= reg_wdata & `PCS_PRESC_MASK;
        end
    end

    // Latch position reads the pin while in input mode
    always @* begin
        latch_view = latch_r;
        if (dir_r[`PCS_BIT_CS])
            latch_view[`PCS_BIT_CS] = cs_lvl_r;
    end

    always @* begin
        rd_nxt = 16'h0000;
        if (reg_addr == `PCS_OFF_LATCH)
            rd_nxt = {8'h00, latch_view};
        else if (reg_addr == `PCS_OFF_DIR)
            rd_nxt = {8'h00, dir_r};
        else if (reg_addr == `PCS_OFF_IBUF)
            rd_nxt = {8'h00, ibuf_r};
        else if (reg_addr == `PCS_OFF_CLKEN)
            rd_nxt = {8'h00, clken_r};
        else if (reg_addr == `PCS_OFF_PRESC)
            rd_nxt = presc_r;
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (!resetn)
            reg_rdata_r <= 16'h0000;
        else if (reg_rd)
            reg_rdata_r <= rd_nxt;
        else
            reg_rdata_r <= 16'h0000;
    end

    // Pin and control outputs, all registered
    always @(posedge sys_clk) begin
        if (!resetn) begin
            cs_pin_o_r    <= 1'b0;
            cs_pin_oe_r   <= 1'b0;
            ttl_sel_r     <= 1'b0;
            unit_clk_en_r <= 1'b0;
            op_clk_tick_r <= 1'b0;
        end else begin
            cs_pin_o_r    <= latch_r[`PCS_BIT_CS];
            cs_pin_oe_r   <= ~dir_r[`PCS_BIT_CS];
            ttl_sel_r     <= ibuf_r[`PCS_BIT_IBUF];
            unit_clk_en_r <= clken_r[`PCS_BIT_GATE];
            // Divided clock stops with the gate as well
            op_clk_tick_r <= tick & clken_r[`PCS_BIT_GATE];
        end
    end

    pcs_prescaler #(
        .CNT_W (15)
    ) u_presc (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .run     (clken_r[`PCS_BIT_GATE]),
        .sel     (presc_r[`PCS_PRS_HI:`PCS_PRS_LO]),
        .tick_r  (tick)
    );
endmodule

// ---- tb/pcs_bank_sva.sv ----
// Checker for the setup bank outputs against register port writes.
// Assumes binding onto pcs_setup_bank; sees its ports only.
`timescale 1ns/1ps
module pcs_bank_sva (
    // Clock and reset
    input wire        sys_clk,
    input wire        resetn,
    // Register port
    input wire [3:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata_r,
    // Pin and clock outputs
    input wire        cs_pin_o_r,
    input wire        cs_pin_oe_r,
    input wire        ttl_sel_r,
    input wire        unit_clk_en_r,
    input wire        op_clk_tick_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    latch_to_pin_a: assert property (reg_wr && reg_addr == 4'h0
        |-> ##2 cs_pin_o_r == $past(reg_wdata[4], 2)) else $error("pin value");
    dir_to_oe_a: assert property (reg_wr && reg_addr == 4'h1
        |-> ##2 cs_pin_oe_r != $past(reg_wdata[4], 2)) else $error("oe value");
    ibuf_sel_a: assert property (reg_wr && reg_addr == 4'h2
        |-> ##2 ttl_sel_r == $past(reg_wdata[1], 2)) else $error("ttl select");
    clk_gate_a: assert property (reg_wr && reg_addr == 4'h3
        |-> ##2 unit_clk_en_r == $past(reg_wdata[2], 2)) else $error("gate");
    gated_tick_a: assert property (!unit_clk_en_r [*4]
        |-> !op_clk_tick_r) else $error("tick while gated");
    rdata_idle_a: assert property (!reg_rd
        |=> reg_rdata_r == 16'h0000) else $error("rdata not idle");
    bits_hold_a: assert property (!reg_wr [*3] |-> $stable(cs_pin_oe_r)
        && $stable(ttl_sel_r) && $stable(unit_clk_en_r)) else $error("drift");
    tick_c: cover property (op_clk_tick_r);
    oe_c: cover property ($rose(cs_pin_oe_r));
    rd_c: cover property (reg_rd ##1 reg_rdata_r != 16'h0000);
endmodule

bind pcs_setup_bank pcs_bank_sva chk (.sys_clk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .cs_pin_o_r, .cs_pin_oe_r,
    .ttl_sel_r, .unit_clk_en_r, .op_clk_tick_r);

// ---- tb/tb_top.sv ----
// Self-checking bench: register rows, pin direction and prescaler.
// Assumes the bank alone, every port driven from here.
`timescale 1ns/1ps
module tb_top;
    reg         sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, cs_pin_i = 0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [15:0] reg_wdata = 16'h0000;
    wire [15:0] reg_rdata_r;
    wire        o, oe, ttl, gate, tick;
    integer     n_fail = 0, checks_done = 0, i, n;
    reg  [35:0] rows [0:5];
    always #4 sys_clk = ~sys_clk;
    pcs_setup_bank dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_r, .cs_pin_i, .cs_pin_o_r(o), .cs_pin_oe_r(oe),
        .ttl_sel_r(ttl), .unit_clk_en_r(gate), .op_clk_tick_r(tick));
    task chk(input string nm, input [15:0] s, input [15:0] e);
        checks_done = checks_done + 1;
        if (s !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] %0s exp %h seen %h", nm, e, s);
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, input [15:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata_r, e);
    endtask
    // Long settle so a restarted count never lands in the window
    task cnt(input integer c, input [15:0] e);
        n = 0;
        repeat (16) @(posedge sys_clk);
        repeat (c) begin
            @(posedge sys_clk);
            #1 n = n + tick;
        end
        chk("ticks", n[15:0], e);
    endtask
    task complete_run;
        $display("mismatches %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000 n_fail = n_fail + 1;
        complete_run;
    end
    initial begin
        rows[0] = {4'h1, 16'h00EF, 16'h00EF};
        rows[1] = {4'h0, 16'h0010, 16'h0010};
        rows[2] = {4'h2, 16'h0002, 16'h0002};
        rows[3] = {4'h3, 16'h0004, 16'h0004};
        rows[4] = {4'h4, 16'hFF03, 16'h0003};
        rows[5] = {4'h5, 16'h1234, 16'h0000};
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(4'h1, 16'h00FF);
        chk("oe", oe, 16'h0000);
        for (i = 0; i < 6; i = i + 1) begin
            wr(rows[i][35:32], rows[i][31:16]);
            rd(rows[i][35:32], rows[i][15:0]);
        end
        chk("pin", o, 16'h0001);
        chk("oe", oe, 16'h0001);
        chk("ttl", ttl, 16'h0001);
        chk("gate", gate, 16'h0001);
        cnt(64, 16'h0008);
        wr(4'h4, 16'h0000);
        cnt(16, 16'h0010);
        wr(4'h0, 16'h0000);
        @(posedge sys_clk);
        #1 chk("pin", o, 16'h0000);
        wr(4'h2, 16'h0000);
        wr(4'h3, 16'h0000);
        cnt(32, 16'h0000);
        chk("ttl", ttl, 16'h0000);
        wr(4'h1, 16'h00FF);
        cs_pin_i <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(4'h0, 16'h0010);
        cs_pin_i <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(4'h0, 16'h0000);
        wr(4'h3, 16'h0004);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(4'h3, 16'h0000);
        rd(4'h1, 16'h00FF);
        chk("gate", gate, 16'h0000);
        complete_run;
    end
endmodule
